// ### spi_port_pkg.sv
// Constants shared by the SPI master/slave port and its receive FIFO
package spi_port_pkg;
    localparam int unsigned CLK_PERIOD_NS = 8;
    // Least SCK phase length from the far master, in CPU clock periods (strictly more than this)
    localparam int unsigned SCK_MIN_PHASE_CLKS = 2;
    localparam int unsigned BYTE_BITS = 8;
    localparam int unsigned CNT_W = 3;
    localparam int unsigned DIV_W = 7;
    localparam int unsigned RATE_W = 3;
    localparam int unsigned RX_FIFO_DEPTH = 16;
    localparam int unsigned RX_FIFO_WIDTH = 8;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [DIV_W-1:0] DIV_RESET = 7'h00;
    localparam logic [CNT_W-1:0] CNT_RESET = 3'h0;
    localparam logic [2:0] SYNC_RESET = 3'h7;
    // Bit-rate selections: half-period in CPU clocks is 2^rate_sel
    localparam logic [RATE_W-1:0] RATE_DIV2 = 3'h0;
    localparam logic [RATE_W-1:0] RATE_DIV4 = 3'h1;
    localparam logic [RATE_W-1:0] RATE_DIV8 = 3'h2;
    localparam logic [RATE_W-1:0] RATE_DIV16 = 3'h3;
    localparam logic [RATE_W-1:0] RATE_DIV32 = 3'h4;
    localparam logic [RATE_W-1:0] RATE_DIV64 = 3'h5;
    localparam logic [RATE_W-1:0] RATE_DIV128 = 3'h6;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_MASTER,
        ST_SLAVE
    } port_state_e;
endpackage : spi_port_pkg

// ### rx_fifo.sv
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module rx_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 16
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic flush,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [$clog2(DEPTH+1)-1:0] level
);
    localparam int unsigned AW = $clog2(DEPTH);
    localparam int unsigned LW = $clog2(DEPTH+1);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [LW-1:0] count;
    } fifo_s;
    fifo_s s_q;
    fifo_s s_d;
    logic push;
    logic pop;

    function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
        ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
    endfunction : ptr_inc

    assign in_ready = (s_q.count != LW'(DEPTH));
    assign out_valid = (s_q.count != '0);
    assign out_data = s_q.mem[s_q.rd_ptr];
    assign level = s_q.count;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        s_d = s_q;
        if (flush) begin
            s_d.wr_ptr = '0;
            s_d.rd_ptr = '0;
            s_d.count = '0;
        end else begin
            if (push) begin
                s_d.mem[s_q.wr_ptr] = in_data;
                s_d.wr_ptr = ptr_inc(s_q.wr_ptr);
            end
            if (pop) begin
                s_d.rd_ptr = ptr_inc(s_q.rd_ptr);
            end
            if (push && !pop) begin
                s_d.count = s_q.count + LW'(1);
            end else if (pop && !push) begin
                s_d.count = s_q.count - LW'(1);
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule : rx_fifo

// ### spi_master_slave_port.sv
// Byte-oriented full-duplex SPI port, master or slave, with receive FIFO
`timescale 1ns/1ps
// Notes on behaviour
// - Port idles while serial_port_power_off is high.
// - MOSI carries master to slave, MISO slave to master, same clock pulses.
// - Master mode never drives select by itself; software owns it.
// - Master: writing a data byte starts the clock, eight bits shift out.
// - Master: after the byte the clock stops and transfer_done_flag sets.
// - Interrupt raised when flag sets and transfer_irq_enable is high.
// - Last received byte stays readable after each transfer.
// - Slave with select high stays idle, MISO released.
// - Deselected slave accepts data writes but ignores SCK.
// - Slave sets the flag per full byte; may load transmit before reading.
// - Transmit single buffered: writes during a shift are refused.
// - Receive buffered; bytes arriving while storage is full are lost and rx_overrun sets.
// - Enabled port forces input pins by mode; output pins follow sck_dir_out, mosi_dir_out, miso_dir_out.
// - Master offers seven SCK bit rates from the CPU clock.
// - Double-speed master option halves the SCK period, down to half CPU clock.
// - Bit order selectable, LSB first or MSB first.
// - Write during a transfer sets the write-collision flag.
// - Slave select rising resets shift logic, drops partial byte.
module spi_master_slave_port
    import spi_port_pkg::*;
#(
    parameter int unsigned FIFO_DEPTH = RX_FIFO_DEPTH
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic serial_port_power_off,
    input wire logic port_enable,
    input wire logic master_select_bit,
    input wire logic lsb_first,
    input wire logic sck_idle_high,
    input wire logic sample_trailing,
    input wire logic [spi_port_pkg::RATE_W-1:0] rate_sel,
    input wire logic double_speed,
    input wire logic transfer_irq_enable,
    input wire logic [7:0] wr_data,
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic status_read,
    input wire logic data_access,
    input wire logic irq_ack,
    output logic [7:0] rd_data,
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [7:0] last_rx_byte,
    output logic transfer_done_flag,
    output logic write_collision,
    output logic rx_overrun,
    output logic busy,
    output logic irq,
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe_n,
    input wire logic mosi_in,
    output logic mosi_out,
    output logic mosi_oe_n,
    input wire logic miso_in,
    output logic miso_out,
    output logic miso_oe_n,
    input wire logic ss_n_in,
    input wire logic sck_dir_out,
    input wire logic mosi_dir_out,
    input wire logic miso_dir_out
);
    typedef struct packed {
        port_state_e state;
        logic [7:0] shift;
        logic [CNT_W-1:0] bits;
        logic [DIV_W-1:0] div;
        logic sck;
        logic half;
        logic out_bit;
        logic [2:0] sck_sync;
        logic [2:0] ss_sync;
        logic sck_stable;
        logic ss_stable;
        logic [7:0] last_rx;
        logic done;
        logic status_seen;
        logic wcol;
        logic overrun;
    } port_s;
    port_s s_q;
    port_s s_d;

    logic active;
    logic is_master;
    logic fifo_in_ready;
    logic rx_push;
    logic [7:0] rx_byte;
    logic wr_fire;
    logic sck_edge;
    logic lead_edge;
    logic trail_edge;
    logic sample_edge;
    logic shift_edge;
    logic [DIV_W-1:0] half_period;

    // Divider reload, one less than the half-period in CPU clocks; double speed halves it
    function automatic logic [DIV_W-1:0] half_clks(input logic [RATE_W-1:0] sel, input logic dbl);
        logic [DIV_W:0] full;
        full = (DIV_W+1)'(1) << (sel + RATE_W'(1));
        if (dbl) begin
            full = full >> 1;
        end
        // Double speed at the top rate stays at clk/2
        if (full < (DIV_W+1)'(2)) begin
            half_clks = '0;
        end else begin
            half_clks = DIV_W'((full >> 1) - (DIV_W+1)'(1));
        end
    endfunction : half_clks

    // Pick the outgoing bit by bit order
    function automatic logic tx_bit(input logic [7:0] d, input logic lsb);
        tx_bit = lsb ? d[0] : d[7];
    endfunction : tx_bit

    // Shift one bit in at the end opposite the outgoing one
    function automatic logic [7:0] shift_in(input logic [7:0] d, input logic b, input logic lsb);
        shift_in = lsb ? {b, d[7:1]} : {d[6:0], b};
    endfunction : shift_in

    // =====================================
    // Mode and handshake
    assign active = port_enable && !serial_port_power_off;
    assign is_master = master_select_bit;
    assign wr_ready = active && (s_q.state == ST_IDLE);
    assign wr_fire = wr_valid && wr_ready;
    assign half_period = half_clks(rate_sel, double_speed);
    assign busy = (s_q.state != ST_IDLE);

    // =====================================
    // Pin drive
    always_comb begin
        sck_out = s_q.sck;
        mosi_out = s_q.out_bit;
        miso_out = s_q.out_bit;
        sck_oe_n = 1'b1;
        mosi_oe_n = 1'b1;
        miso_oe_n = 1'b1;
        if (active && is_master) begin
            sck_oe_n = !sck_dir_out;
            mosi_oe_n = !mosi_dir_out;
        end else if (active && !s_q.ss_stable) begin
            miso_oe_n = !miso_dir_out;
        end
    end

    // =====================================
    // Slave SCK edge detection on filtered copies
    always_comb begin
        sck_edge = 1'b0;
        if (s_q.sck_sync[2] == s_q.sck_sync[1] && s_q.sck_sync[1] != s_q.sck_stable) begin
            sck_edge = 1'b1;
        end
        lead_edge = sck_edge && (s_q.sck_sync[1] != sck_idle_high);
        trail_edge = sck_edge && (s_q.sck_sync[1] == sck_idle_high);
        sample_edge = sample_trailing ? trail_edge : lead_edge;
        shift_edge = sample_trailing ? lead_edge : trail_edge;
    end

    // =====================================
    // Port state machine
    always_comb begin
        s_d = s_q;
        rx_push = 1'b0;
        rx_byte = s_q.shift;
        s_d.sck_sync = {s_q.sck_sync[1:0], sck_in};
        s_d.ss_sync = {s_q.ss_sync[1:0], ss_n_in};
        if (s_q.sck_sync[2] == s_q.sck_sync[1]) begin
            s_d.sck_stable = s_q.sck_sync[1];
        end
        if (s_q.ss_sync[2] == s_q.ss_sync[1]) begin
            s_d.ss_stable = s_q.ss_sync[1];
        end
        if (status_read && s_q.done) begin
            s_d.status_seen = 1'b1;
        end
        if (irq_ack || (s_q.status_seen && data_access)) begin
            s_d.done = 1'b0;
            s_d.wcol = 1'b0;
            s_d.status_seen = 1'b0;
        end
        // Write attempted while a byte is shifting; a new attempt wins over a clear
        if (wr_valid && active && s_q.state != ST_IDLE) begin
            s_d.wcol = 1'b1;
        end
        case (s_q.state)
            ST_IDLE: begin
                s_d.sck = sck_idle_high;
                if (!active) begin
                    s_d.sck = sck_idle_high;
                end else if (wr_fire) begin
                    s_d.shift = wr_data;
                    s_d.out_bit = tx_bit(wr_data, lsb_first);
                    if (is_master) begin
                        s_d.state = ST_MASTER;
                        s_d.div = half_period;
                        s_d.half = 1'b0;
                        s_d.bits = CNT_RESET;
                    end
                end else if (!is_master && !s_q.ss_stable) begin
                    s_d.state = ST_SLAVE;
                    s_d.bits = CNT_RESET;
                    s_d.out_bit = tx_bit(s_q.shift, lsb_first);
                end
            end
            ST_MASTER: begin
                if (!active || !is_master) begin
                    s_d.state = ST_IDLE;
                    s_d.sck = sck_idle_high;
                end else if (s_q.div != '0) begin
                    s_d.div = s_q.div - DIV_W'(1);
                end else begin
                    s_d.div = half_period;
                    s_d.sck = !s_q.sck;
                    s_d.half = !s_q.half;
                    if ((!s_q.half) != sample_trailing) begin
                        s_d.shift = shift_in(s_q.shift, miso_in, lsb_first);
                    end else begin
                        s_d.out_bit = tx_bit(s_q.shift, lsb_first);
                    end
                    if (s_q.half) begin
                        s_d.bits = s_q.bits + CNT_W'(1);
                        if (s_q.bits == CNT_W'(BYTE_BITS - 1)) begin
                            s_d.state = ST_IDLE;
                            s_d.done = 1'b1;
                            rx_push = 1'b1;
                            rx_byte = sample_trailing ? shift_in(s_q.shift, miso_in, lsb_first) : s_q.shift;
                            s_d.last_rx = rx_byte;
                            if (sample_trailing) begin
                                s_d.shift = rx_byte;
                            end
                        end
                    end
                end
            end
            ST_SLAVE: begin
                if (!active || is_master || s_q.ss_stable) begin
                    s_d.state = ST_IDLE;
                    s_d.bits = CNT_RESET;
                end else if (sample_edge) begin
                    s_d.shift = shift_in(s_q.shift, mosi_in, lsb_first);
                    s_d.bits = s_q.bits + CNT_W'(1);
                    if (s_q.bits == CNT_W'(BYTE_BITS - 1)) begin
                        s_d.done = 1'b1;
                        rx_push = 1'b1;
                        rx_byte = shift_in(s_q.shift, mosi_in, lsb_first);
                        s_d.last_rx = rx_byte;
                        s_d.out_bit = tx_bit(rx_byte, lsb_first);
                    end
                end else if (shift_edge && s_q.bits != CNT_RESET) begin
                    s_d.out_bit = tx_bit(s_q.shift, lsb_first);
                end
            end
            default: begin
                s_d.state = ST_IDLE;
            end
        endcase
        if (rx_push && !fifo_in_ready) begin
            s_d.overrun = 1'b1;
        end else if (irq_ack) begin
            s_d.overrun = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            s_q.state <= ST_IDLE;
            s_q.shift <= DATA_RESET;
            s_q.bits <= CNT_RESET;
            s_q.div <= DIV_RESET;
            s_q.sck <= 1'b0;
            s_q.half <= 1'b0;
            s_q.out_bit <= 1'b0;
            s_q.sck_sync <= SYNC_RESET;
            s_q.ss_sync <= SYNC_RESET;
            s_q.sck_stable <= 1'b1;
            s_q.ss_stable <= 1'b1;
            s_q.last_rx <= DATA_RESET;
            s_q.done <= 1'b0;
            s_q.status_seen <= 1'b0;
            s_q.wcol <= 1'b0;
            s_q.overrun <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // =====================================
    // Receive buffer
    rx_fifo #(
        .WIDTH(RX_FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_rx_fifo (
        .clock(clock),
        .rstn(rstn),
        .flush(!active),
        .in_data(rx_byte),
        .in_valid(rx_push),
        .in_ready(fifo_in_ready),
        .out_data(rd_data),
        .out_valid(rd_valid),
        .out_ready(rd_ready),
        .level()
    );

    assign last_rx_byte = s_q.last_rx;
    assign transfer_done_flag = s_q.done;
    assign write_collision = s_q.wcol;
    assign rx_overrun = s_q.overrun;
    assign irq = s_q.done && transfer_irq_enable;
endmodule : spi_master_slave_port

// ### spi_port_properties.sv
// Pin-level assertions for the SPI master/slave port
`timescale 1ns/1ps
module spi_port_checker (
    input wire logic clock,
    input wire logic rstn,
    input wire logic serial_port_power_off,
    input wire logic port_enable,
    input wire logic master_select_bit,
    input wire logic transfer_irq_enable,
    input wire logic wr_valid,
    input wire logic wr_ready,
    input wire logic irq_ack,
    input wire logic data_access,
    input wire logic busy,
    input wire logic transfer_done_flag,
    input wire logic write_collision,
    input wire logic irq,
    input wire logic sck_out,
    input wire logic sck_oe_n,
    input wire logic mosi_oe_n,
    input wire logic miso_oe_n,
    input wire logic ss_n_in
);
    wire on = port_enable & ~serial_port_power_off;
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    // ============
    // Properties
    property p_off_idle;
        serial_port_power_off && $past(serial_port_power_off) |-> !busy && !wr_ready && sck_oe_n && mosi_oe_n && miso_oe_n;
    endproperty
    a_off_idle: assert property (p_off_idle) else $error("port active while off");
    property p_pin_dirs;
        on && $past(on) && $stable(master_select_bit) |-> (master_select_bit ? miso_oe_n : sck_oe_n && mosi_oe_n);
    endproperty
    a_pin_dirs: assert property (p_pin_dirs) else $error("pin direction wrong");
    property p_deselected;
        (on && !master_select_bit && ss_n_in) [*6] |-> miso_oe_n && !busy;
    endproperty
    a_deselected: assert property (p_deselected) else $error("deselected slave not idle");
    property p_refuse;
        busy |-> !wr_ready;
    endproperty
    a_refuse: assert property (p_refuse) else $error("write accepted while busy");
    property p_collision;
        busy && wr_valid && !irq_ack && !data_access |=> write_collision;
    endproperty
    a_collision: assert property (p_collision) else $error("collision not flagged");
    property p_done;
        on && master_select_bit && $fell(busy) |-> transfer_done_flag;
    endproperty
    a_done: assert property (p_done) else $error("no done flag after byte");
    property p_halt;
        on && master_select_bit && $stable(master_select_bit) && !busy && !$past(busy) && !$past(busy, 2) |-> $stable(sck_out);
    endproperty
    a_halt: assert property (p_halt) else $error("clock runs while idle");
    property p_irq;
        $rose(transfer_done_flag) |-> irq == transfer_irq_enable;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt request wrong");
endmodule : spi_port_checker

bind spi_master_slave_port spi_port_checker spi_port_checker_i (.clock, .rstn, .serial_port_power_off, .port_enable,
    .master_select_bit, .transfer_irq_enable, .wr_valid, .wr_ready, .irq_ack, .data_access, .busy, .transfer_done_flag,
    .write_collision, .irq, .sck_out, .sck_oe_n, .mosi_oe_n, .miso_oe_n, .ss_n_in);

// ### spi_far_end.sv
// Far-side SPI device: slave for a master port, master for a slave port
`timescale 1ns/1ps
module spi_far_end (
    input wire logic clock,
    input wire logic lsb,
    input wire logic cpol,
    input wire logic sck,
    input wire logic mosi,
    input wire logic ss_n,
    output logic miso,
    output logic m_sck,
    output logic m_mosi,
    output logic m_ss_n,
    input wire logic m_miso
);
    localparam int HALF = 8;
    logic [7:0] sh = 8'h00;
    logic [7:0] rx = 8'h00;
    logic last = 1'b0;
    wire bit_out = lsb ? sh[0] : sh[7];
    // Released line shows the inverse of its last value
    assign miso = ss_n ? ~last : bit_out;
    always @(posedge clock) if (!ss_n) last <= bit_out;
    always @(posedge sck) if (!ss_n) rx <= lsb ? {mosi, rx[7:1]} : {rx[6:0], mosi};
    always @(negedge sck) if (!ss_n) sh <= lsb ? sh >> 1 : sh << 1;
    initial begin
        m_sck = 1'b0;
        m_mosi = 1'b0;
        m_ss_n = 1'b1;
    end
    // Fewer than eight bits breaks off mid-byte; sel low keeps select high; cpol sets the idle level
    task automatic xfer(input logic [7:0] tx, input int nbits, input logic sel, output logic [7:0] got);
        got = 8'h00;
        m_sck = cpol;
        m_ss_n = ~sel;
        for (int i = 0; i < nbits; i++) begin
            if (!cpol) begin
                m_mosi = lsb ? tx[i] : tx[7 - i];
            end
            repeat (HALF) @(negedge clock);
            m_sck = ~cpol;
            if (cpol) begin
                m_mosi = lsb ? tx[i] : tx[7 - i];
            end else begin
                got = lsb ? {m_miso, got[7:1]} : {got[6:0], m_miso};
            end
            repeat (HALF) @(negedge clock);
            m_sck = cpol;
            if (cpol) begin
                got = lsb ? {m_miso, got[7:1]} : {got[6:0], m_miso};
            end
        end
        repeat (HALF) @(negedge clock);
        m_ss_n = 1'b1;
        m_mosi = ~m_mosi;
        repeat (HALF) @(negedge clock);
    endtask : xfer
endmodule : spi_far_end

// ### tb.sv
// Self-checking bench for the SPI master/slave port
`timescale 1ns/1ps
module tb;
    import spi_port_pkg::*;
    typedef struct packed {logic [3:0] rate; logic dbl; logic lsb; logic clash; logic pad; logic [23:0] bytes;} row_s;
    // Rate, flags, sent byte, far byte, expected SCK period
    row_s rows [9] = '{32'h00A53C02, 32'h145AC304, 32'h20817E08, 32'h34018010, 32'h40FF0020, 32'h546DB240,
        32'h6018E780, 32'h0C2CD402, 32'h3A934908};
    logic clock, rstn, serial_port_power_off, port_enable, master_select_bit, lsb_first, sck_idle_high, sample_trailing;
    logic double_speed, transfer_irq_enable, wr_valid, status_read, data_access, irq_ack, rd_ready, sck_dir_out;
    logic mosi_dir_out, miso_dir_out, wr_ready, rd_valid, transfer_done_flag, write_collision, rx_overrun, busy, irq;
    logic sck_out, sck_oe_n, mosi_out, mosi_oe_n, miso_out, miso_oe_n, far_miso, m_sck, m_mosi, m_ss_n, sel_n, sck_prev;
    logic [RATE_W-1:0] rate_sel;
    logic [7:0] wr_data, rd_data, last_rx_byte, per, got;
    int error_cnt = 0, compares = 0, cycles = 0, rise_at = 0;
    spi_master_slave_port spi_master_slave_port_i (.clock, .rstn, .serial_port_power_off, .port_enable, .master_select_bit,
        .lsb_first, .sck_idle_high, .sample_trailing, .rate_sel, .double_speed, .transfer_irq_enable, .wr_data, .wr_valid,
        .wr_ready, .status_read, .data_access, .irq_ack, .rd_data, .rd_valid, .rd_ready, .last_rx_byte, .transfer_done_flag,
        .write_collision, .rx_overrun, .busy, .irq, .sck_in(m_sck), .sck_out, .sck_oe_n, .mosi_in(m_mosi), .mosi_out,
        .mosi_oe_n, .miso_in(far_miso), .miso_out, .miso_oe_n, .ss_n_in(m_ss_n), .sck_dir_out, .mosi_dir_out, .miso_dir_out);
    spi_far_end spi_far_end_i (.clock, .lsb(lsb_first), .cpol(sck_idle_high), .sck(sck_out), .mosi(mosi_out), .ss_n(sel_n),
        .miso(far_miso), .m_sck, .m_mosi, .m_ss_n, .m_miso(miso_oe_n ? ~miso_out : miso_out));
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // SCK period meter and run limit
    always @(posedge clock) begin
        cycles++;
        sck_prev <= sck_out;
        if (sck_out === 1'b1 && sck_prev === 1'b0) begin
            per <= 8'(cycles - rise_at);
            rise_at <= cycles;
        end
        if (cycles == 20000) begin
            error_cnt++;
            give_verdict();
        end
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic tick(ref logic s);
        s = 1'b1;
        @(negedge clock);
        s = 1'b0;
    endtask : tick
    task automatic mbyte(input logic [7:0] d, input logic [7:0] s, input logic clash);
        int n;
        n = 0;
        spi_far_end_i.sh = s;
        sel_n = 1'b0;
        wr_data = d;
        wr_valid = 1'b1;
        @(negedge clock);
        chk(busy, 1'b1);
        chk(wr_ready, 1'b0);
        wr_data = ~d;
        wr_valid = clash;
        @(negedge clock);
        wr_valid = 1'b0;
        chk(write_collision, clash);
        while (busy !== 1'b0 && n < 3000) begin
            @(negedge clock);
            n++;
        end
        chk({transfer_done_flag, irq}, {1'b1, transfer_irq_enable});
        chk(spi_far_end_i.rx, d);
        chk(last_rx_byte, s);
        sel_n = 1'b1;
        if (clash) begin
            tick(status_read);
            tick(data_access);
        end else begin
            tick(irq_ack);
        end
        chk(transfer_done_flag, 1'b0);
    endtask : mbyte
    task automatic give_verdict();
        if (error_cnt == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : give_verdict
    // ============
    // Main sequence
    initial begin
        {rstn, serial_port_power_off, lsb_first, sck_idle_high, sample_trailing, double_speed, wr_valid} = '0;
        {status_read, data_access, irq_ack, rd_ready, rate_sel, wr_data} = '0;
        {port_enable, master_select_bit, transfer_irq_enable, sck_dir_out, mosi_dir_out, miso_dir_out, sel_n} = 7'h7F;
        repeat (12) @(negedge clock);
        chk({transfer_done_flag, busy, rd_valid, sck_oe_n, mosi_oe_n, miso_oe_n}, 8'h01);
        rstn = 1'b1;
        @(negedge clock);
        foreach (rows[i]) begin
            rate_sel = rows[i].rate[RATE_W-1:0];
            double_speed = rows[i].dbl;
            lsb_first = rows[i].lsb;
            transfer_irq_enable = i[0];
            mbyte(rows[i].bytes[23:16], rows[i].bytes[15:8], rows[i].clash);
            chk(per, rows[i].bytes[7:0]);
            chk(rd_data, rows[i].bytes[15:8]);
            tick(rd_ready);
        end
        serial_port_power_off = 1'b1;
        tick(wr_valid);
        chk({busy, wr_ready, sck_oe_n, mosi_oe_n, miso_oe_n}, 8'h07);
        serial_port_power_off = 1'b0;
        // ============
        // Slave side: partial frame, deselected clocks, full byte, overflow
        {master_select_bit, lsb_first, transfer_irq_enable} = 3'h1;
        repeat (4) @(negedge clock);
        spi_far_end_i.xfer(8'hFF, 5, 1'b1, got);
        chk(transfer_done_flag, 1'b0);
        wr_data = 8'h96;
        tick(wr_valid);
        chk(miso_oe_n, 1'b1);
        spi_far_end_i.xfer(8'h33, 8, 1'b0, got);
        chk({transfer_done_flag, rd_valid}, 8'h00);
        spi_far_end_i.xfer(8'h4B, 8, 1'b1, got);
        chk(got, 8'h96);
        chk(last_rx_byte, 8'h4B);
        chk(irq, 1'b1);
        tick(irq_ack);
        tick(rd_ready);
        for (int i = 0; i < 17; i++) spi_far_end_i.xfer(8'hA0 + 8'(i), 8, 1'b1, got);
        chk(rx_overrun, 1'b1);
        for (int i = 0; i < 16; i++) begin
            chk(rd_data, 8'hA0 + 8'(i));
            tick(rd_ready);
        end
        chk(rd_valid, 1'b0);
        chk(last_rx_byte, 8'hB0);
        // Slave byte with idle-high clock, sampled on the trailing edge
        {sck_idle_high, sample_trailing, wr_data} = {2'h3, 8'h5A};
        tick(wr_valid);
        spi_far_end_i.xfer(8'h00, 0, 1'b0, got);
        spi_far_end_i.xfer(8'hC5, 8, 1'b1, got);
        chk(got, 8'h5A);
        chk(last_rx_byte, 8'hC5);
        chk(rd_data, 8'hC5);
        give_verdict();
    end
endmodule : tb
